// File: hw/dbf_pkg.sv
// package: constants and types for the dual-band complex lane framer
package dbf_pkg;
	// ------------------------------------------------------------
	// apb register map
	// ------------------------------------------------------------
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	localparam logic [11:0] DROP_OFS = 12'h008;
	// ctrl fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_FOUR_BIT = 1;
	localparam int CTRL_DEC_LSB = 4;
	localparam int DEC_W = 3;
	// stat fields
	localparam int STAT_ILLEGAL_BIT = 0;
	localparam int STAT_RUN_BIT = 1;
	localparam int STAT_MULT_BIT = 2;
	localparam int STAT_FSEL_LSB = 4;
	localparam int STAT_RATIO_LSB = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// ------------------------------------------------------------
	// decimation codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		DEC_8 = 3'h0,
		DEC_9 = 3'h1,
		DEC_10 = 3'h2,
		DEC_12 = 3'h3,
		DEC_16 = 3'h4,
		DEC_18 = 3'h5,
		DEC_20 = 3'h6,
		DEC_24_32 = 3'h7
	} dbf_dec_t;
	// framing selects and multipliers
	localparam logic [2:0] FSEL_EIGHT = 3'h1;
	localparam logic [2:0] FSEL_FOUR = 3'h2;
	localparam logic MULT_20X = 1'b0;
	localparam logic MULT_40X = 1'b1;
	// ------------------------------------------------------------
	// link shape
	// ------------------------------------------------------------
	localparam int SAMP_W = 16;
	localparam int OCT_W = 8;
	localparam int STREAMS = 8;
	localparam int LANES = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int WORD_W = SAMP_W * STREAMS;
	// octets per frame, minus one, for counters
	localparam logic [1:0] LAST_OCT_EIGHT = 2'h1;
	localparam logic [1:0] LAST_OCT_FOUR = 2'h3;
	// lane ratio in quarter steps (x4): 8821 and 4841 at decimation 8 and 20
	localparam logic [7:0] RATIO_Q8 = 8'h0a;
	localparam logic [7:0] RATIO_Q20 = 8'h04;
	localparam logic [7:0] RATIO_Q4_32 = 8'h05;
endpackage : dbf_pkg

// File: hw/dbf_stream_if.sv
// interface: valid/ready sample word stream between framer parts
`timescale 1ns/1ps
interface dbf_stream_if #(parameter int W = 128) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : dbf_stream_if

// File: hw/dbf_fifo.sv
// module: flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module dbf_fifo #(
	parameter int W = 128,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	dbf_stream_if.snk in_s,
	dbf_stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} dbf_fifo_st_t;
	dbf_fifo_st_t st_reg;
	dbf_fifo_st_t st_next;
	logic push;
	logic pop;

	// full at DEPTH words; the count is one bit wider than the pointers
	assign in_s.ready = (st_reg.cnt < (AW+1)'(DEPTH));
	assign out_s.valid = (st_reg.cnt != '0);
	assign out_s.data = st_reg.mem[st_reg.rd];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wr] = in_s.data;
			st_next.wr = (st_reg.wr == AW'(DEPTH - 1)) ? '0 : st_reg.wr + 1'b1;
		end
		if (pop) begin
			st_next.rd = (st_reg.rd == AW'(DEPTH - 1)) ? '0 : st_reg.rd + 1'b1;
		end
		st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_reg <= '0;
		end else if (ce_i) begin
			st_reg <= st_next;
		end
	end
endmodule : dbf_fifo

// File: hw/dbf_lane_map.sv
// module: maps one frame octet slot of eight streams onto eight lanes
`timescale 1ns/1ps
module dbf_lane_map (
	input wire logic four_lane_i,
	input wire logic [1:0] oct_i,
	input wire logic [dbf_pkg::WORD_W-1:0] word_i,
	output logic [dbf_pkg::LANES-1:0][dbf_pkg::OCT_W-1:0] lane_o,
	output logic [dbf_pkg::LANES-1:0] lane_en_o
);
	// word holds streams a1i,a1q,a2i,a2q,b1i,b1q,b2i,b2q (index 0..7)
	logic [dbf_pkg::STREAMS-1:0][dbf_pkg::SAMP_W-1:0] s;
	assign s = word_i;

	for (genvar c = 0; c < 2; c++) begin : g_chan
		for (genvar l = 0; l < 4; l++) begin : g_lane
			localparam int LN = c * 4 + l;
			// first stream of the lane's band; idle lanes stay in range
			localparam int FL = ((l == 1) || (l == 2)) ?
				c * 4 + (l - 1) * 2 : c * 4;
			logic [dbf_pkg::SAMP_W-1:0] smp;
			logic hi;
			always_comb begin
				smp = s[LN];
				hi = ~oct_i[0];
				lane_en_o[LN] = 1'b1;
				if (four_lane_i) begin
					// lanes 1 and 2 carry band 1 / band 2, i then q
					lane_en_o[LN] = (l == 1) || (l == 2);
					smp = s[FL + (oct_i[1] ? 1 : 0)];
				end
				// upper octet first, then lower
				lane_o[LN] = hi ? smp[dbf_pkg::SAMP_W-1:dbf_pkg::OCT_W] :
					smp[dbf_pkg::OCT_W-1:0];
				if (!lane_en_o[LN]) begin
					lane_o[LN] = '0;
				end
			end
		end
	end
endmodule : dbf_lane_map

// File: hw/dbf_framer.sv
// module: top of the dual-band complex lane framer with apb registers
//
// Functional notes
// - Two down-converters per channel give I and Q each, eight streams.
// - Eight-lane mode uses two octets per frame, 20X, selects 1,0,0.
// - Four-lane mode uses four octets per frame, 40X, selects 2,0,0.
// - Decimation 24 and 32 are legal only in four-lane mode.
// - Lane rate is sample clock times the ratio reported per mode; the status ratio reads 0 except at decimation 8, 20 and 24/32.
// - Eight lanes carry band1 I, band1 Q, band2 I, band2 Q, msb octet first.
// - Four lanes use lanes 1 and 2, each carrying I then Q of one band.
// - Channel B lanes use exactly channel A's ordering.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module dbf_framer (
	// clock, reset, enable
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic CE_I,
	// apb slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// converter sample streams, one word per frame
	input wire logic SAMP_VALID_I,
	input wire logic [dbf_pkg::WORD_W-1:0] SAMP_DATA_I,
	output logic SAMP_READY_O,
	// lanes, index 0..3 chan a, 4..7 chan b
	output logic [dbf_pkg::LANES-1:0][dbf_pkg::OCT_W-1:0] LANE_DATA_O,
	output logic [dbf_pkg::LANES-1:0] LANE_EN_O,
	output logic FRAME_START_O,
	// link configuration pins
	output logic [1:0] FRAMING_SELECT_0_O,
	output logic FRAMING_SELECT_1_O,
	output logic FRAMING_SELECT_2_O,
	output logic MULT_40X_O
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01
	} dbf_fsm_t;

	typedef struct packed {
		dbf_fsm_t fsm;
		logic [31:0] ctrl;
		logic [31:0] drops;
		logic [31:0] prdata;
		logic [1:0] oct;
		logic [dbf_pkg::WORD_W-1:0] word;
		logic [dbf_pkg::LANES-1:0][dbf_pkg::OCT_W-1:0] lane;
		logic [dbf_pkg::LANES-1:0] lane_en;
		logic fstart;
	} dbf_top_st_t;

	dbf_top_st_t st_reg;
	dbf_top_st_t st_next;

	dbf_stream_if #(.W(dbf_pkg::WORD_W)) fin_s ();
	dbf_stream_if #(.W(dbf_pkg::WORD_W)) fout_s ();

	logic enable;
	logic four_lane;
	dbf_pkg::dbf_dec_t dec;
	logic illegal;
	logic run;
	logic [1:0] last_oct;
	logic [2:0] fsel;
	logic [7:0] ratio_q;
	logic [31:0] stat;
	logic apb_acc;
	logic apb_wr;
	logic [dbf_pkg::LANES-1:0][dbf_pkg::OCT_W-1:0] map_lane;
	logic [dbf_pkg::LANES-1:0] map_en;

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	assign enable = st_reg.ctrl[dbf_pkg::CTRL_EN_BIT];
	assign four_lane = st_reg.ctrl[dbf_pkg::CTRL_FOUR_BIT];
	assign dec = dbf_pkg::dbf_dec_t'(st_reg.ctrl[dbf_pkg::CTRL_DEC_LSB +:
		dbf_pkg::DEC_W]);
	// decimation 24/32 only fit the four-lane link
	assign illegal = (dec == dbf_pkg::DEC_24_32) && !four_lane;
	assign run = enable && !illegal;
	assign last_oct = four_lane ? dbf_pkg::LAST_OCT_FOUR :
		dbf_pkg::LAST_OCT_EIGHT;
	assign fsel = four_lane ? dbf_pkg::FSEL_FOUR : dbf_pkg::FSEL_EIGHT;

	// lane ratio in quarters; four-lane doubles the eight-lane figure except at decimation 24/32
	always_comb begin
		unique case (dec)
			dbf_pkg::DEC_8: ratio_q = dbf_pkg::RATIO_Q8;
			dbf_pkg::DEC_20: ratio_q = dbf_pkg::RATIO_Q20;
			dbf_pkg::DEC_24_32: ratio_q = dbf_pkg::RATIO_Q4_32;
			default: ratio_q = 8'h00;
		endcase
		if (four_lane && dec != dbf_pkg::DEC_24_32) begin
			ratio_q = ratio_q << 1;
		end
	end

	assign stat = {16'h0000, ratio_q, 1'b0, fsel[2:0], 1'b0,
		four_lane ? dbf_pkg::MULT_40X : dbf_pkg::MULT_20X,
		run, illegal};

	// ------------------------------------------------------------
	// buffering and lane mapping
	// ------------------------------------------------------------
	// eight streams from two converters per channel form one word
	assign fin_s.valid = SAMP_VALID_I && run;
	assign fin_s.data = SAMP_DATA_I;
	assign SAMP_READY_O = fin_s.ready && run;

	dbf_fifo #(.W(dbf_pkg::WORD_W), .DEPTH(dbf_pkg::FIFO_DEPTH)) u_fifo (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.ce_i(CE_I),
		.in_s(fin_s),
		.out_s(fout_s)
	);

	// one mapper serves both channels, so b matches a by construction
	dbf_lane_map u_map (
		.four_lane_i(four_lane),
		.oct_i(st_reg.oct),
		.word_i(st_reg.word),
		.lane_o(map_lane),
		.lane_en_o(map_en)
	);

	// fifo drains only when idle or on the last octet of a frame: back-pressure
	assign fout_s.ready = run && ((st_reg.fsm == ST_IDLE) ||
		(st_reg.oct == last_oct));

	// ------------------------------------------------------------
	// apb
	// ------------------------------------------------------------
	assign apb_acc = PSEL_I && PENABLE_I;
	assign apb_wr = apb_acc && PWRITE_I;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.fstart = 1'b0;
		if (apb_wr && PADDR_I == dbf_pkg::CTRL_OFS) begin
			st_next.ctrl = PWDATA_I;
		end
		if (apb_wr && PADDR_I == dbf_pkg::DROP_OFS) begin
			st_next.drops = '0;
		end
		if (SAMP_VALID_I && !run) begin
			st_next.drops = st_reg.drops + 32'h0000_0001;
		end
		unique case (PADDR_I)
			dbf_pkg::CTRL_OFS: st_next.prdata = st_reg.ctrl;
			dbf_pkg::STAT_OFS: st_next.prdata = stat;
			dbf_pkg::DROP_OFS: st_next.prdata = st_reg.drops;
			default: st_next.prdata = '0;
		endcase
		unique case (st_reg.fsm)
			ST_IDLE: begin
				if (fout_s.valid && fout_s.ready) begin
					st_next.word = fout_s.data;
					st_next.oct = '0;
					st_next.fstart = 1'b1;
					st_next.fsm = ST_SEND;
				end
			end
			ST_SEND: begin
				if (st_reg.oct != last_oct) begin
					st_next.oct = st_reg.oct + 2'h1;
				end else if (fout_s.valid && fout_s.ready) begin
					st_next.word = fout_s.data;
					st_next.oct = '0;
					st_next.fstart = 1'b1;
				end else begin
					st_next.fsm = ST_IDLE;
				end
				if (!run) begin
					st_next.fsm = ST_IDLE;
				end
			end
			default: st_next.fsm = ST_IDLE;
		endcase
		st_next.lane = map_lane;
		st_next.lane_en = (st_reg.fsm == ST_SEND) ? map_en : '0;
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			st_reg <= '0;
			st_reg.ctrl <= dbf_pkg::CTRL_RST;
		end else if (CE_I) begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign PRDATA_O = st_reg.prdata;
	assign PREADY_O = apb_acc;
	assign PSLVERR_O = 1'b0;
	assign LANE_DATA_O = st_reg.lane;
	assign LANE_EN_O = st_reg.lane_en;
	assign FRAME_START_O = st_reg.fstart;
	// select 0 carries the value 1 or 2; selects 1 and 2 stay low here
	assign FRAMING_SELECT_0_O = fsel[1:0];
	assign FRAMING_SELECT_1_O = 1'b0;
	assign FRAMING_SELECT_2_O = 1'b0;
	assign MULT_40X_O = st_reg.ctrl[dbf_pkg::CTRL_FOUR_BIT];
endmodule : dbf_framer

// File: verification/dbf_rx_model.sv
// partner: receiver model that rebuilds sample words from the lanes
`timescale 1ns/1ps
module dbf_rx_model (
	// clock
	input wire logic clk_i,
	// lanes and framing
	input wire logic [dbf_pkg::LANES-1:0][dbf_pkg::OCT_W-1:0] lane_i,
	input wire logic fs_i,
	input wire logic four_i,
	// rebuilt word
	output logic [dbf_pkg::WORD_W-1:0] word_o,
	output logic done_o
);
	// ------------------------------------------------------------
	// octet slot tracking
	// ------------------------------------------------------------
	// slot starts high so that no word is claimed before the first frame
	int o = 99;
	logic fq = 1'b0;
	logic [dbf_pkg::WORD_W-1:0] w;
	always @(posedge clk_i) begin
		o = fq ? 0 : o + 1;
		fq <= fs_i;
		done_o <= 1'b0;
		if (o < 4) begin
			for (int c = 0; c < 2; c++)
				for (int b = 0; b < 4; b++)
					if (!four_i)
						w[(c*4+b)*16+8*(1-o%2)+:8] = lane_i[c*4+b];
					else if (b < 2)
						w[(c*4+2*b+o/2)*16+8*(1-o%2)+:8] = lane_i[c*4+1+b];
		end
		if (o == (four_i ? 3 : 1)) begin
			word_o <= w;
			done_o <= 1'b1;
		end
	end
endmodule : dbf_rx_model

// File: verification/dbf_framer_chk.sv
// checker: port assertions of the lane framer
`timescale 1ns/1ps
module dbf_framer_chk (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_B_I,
	// apb
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PRDATA_O,
	// lanes and link pins
	input wire logic [dbf_pkg::LANES-1:0] LANE_EN_O,
	input wire logic FRAME_START_O,
	input wire logic [1:0] FRAMING_SELECT_0_O,
	input wire logic FRAMING_SELECT_1_O,
	input wire logic FRAMING_SELECT_2_O,
	input wire logic MULT_40X_O
);
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RST_B_I);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	fsel_pins_a: assert property (
		{FRAMING_SELECT_2_O, FRAMING_SELECT_1_O, FRAMING_SELECT_0_O} ==
		(MULT_40X_O ? 4'h2 : 4'h1)) else $error("framing pins");
	eight_lanes_a: assert property (
		FRAME_START_O && !MULT_40X_O |=> (LANE_EN_O == 8'hff) [*2])
		else $error("eight lane enables");
	four_lanes_a: assert property (
		FRAME_START_O && MULT_40X_O |=> (LANE_EN_O == 8'h66) [*4])
		else $error("four lane enables");
	eight_period_a: assert property (
		FRAME_START_O && !MULT_40X_O |=> !FRAME_START_O)
		else $error("eight lane frame length");
	four_period_a: assert property (
		FRAME_START_O && MULT_40X_O |=> !FRAME_START_O [*3])
		else $error("four lane frame length");
	chan_mirror_a: assert property (
		LANE_EN_O[7:4] == LANE_EN_O[3:0]) else $error("channel lanes differ");
	stream_count_a: assert property (
		LANE_EN_O != 8'h00 |->
		$countones(LANE_EN_O) * (MULT_40X_O ? 4 : 2) == 16)
		else $error("octets per frame");
	stat_shape_a: assert property (
		PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == dbf_pkg::STAT_OFS |->
		PRDATA_O[6:4] == (PRDATA_O[2] ? 3'h2 : 3'h1) &&
		!(PRDATA_O[0] && PRDATA_O[2])) else $error("status shape");
endmodule : dbf_framer_chk
bind dbf_framer dbf_framer_chk chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
	.PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
	.PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .LANE_EN_O(LANE_EN_O),
	.FRAME_START_O(FRAME_START_O),
	.FRAMING_SELECT_0_O(FRAMING_SELECT_0_O),
	.FRAMING_SELECT_1_O(FRAMING_SELECT_1_O),
	.FRAMING_SELECT_2_O(FRAMING_SELECT_2_O), .MULT_40X_O(MULT_40X_O));

// File: verification/dbf_framer_test.sv
// bench: framer registers, mode table and lane traffic
`timescale 1ns/1ps
module dbf_framer_test;
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, sv = 1'b0;
	logic [11:0] padr = 12'h000;
	logic [31:0] pwd = 32'h0, prd, rd;
	logic pready, srdy, fs, f1, f2, m40, done, perr;
	logic [1:0] f0;
	logic [dbf_pkg::WORD_W-1:0] sd = '0, word;
	logic [dbf_pkg::WORD_W-1:0] exp_q[$];
	logic [dbf_pkg::LANES-1:0][dbf_pkg::OCT_W-1:0] lanes;
	logic [dbf_pkg::LANES-1:0] len;
	logic [15:0] m;
	int mismatches = 0, num_checks = 0, cyc = 0, full = 0, n;
	always #5 clk = ~clk;
	// clock enable tied: freezing is outside the framing rules
	dbf_framer dut (.CLK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1),
		.PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr),
		.PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr),
		.SAMP_VALID_I(sv), .SAMP_DATA_I(sd), .SAMP_READY_O(srdy),
		.LANE_DATA_O(lanes), .LANE_EN_O(len), .FRAME_START_O(fs),
		.FRAMING_SELECT_0_O(f0), .FRAMING_SELECT_1_O(f1),
		.FRAMING_SELECT_2_O(f2), .MULT_40X_O(m40));
	dbf_rx_model rx (.clk_i(clk), .lane_i(lanes), .fs_i(fs), .four_i(m40),
		.word_o(word), .done_o(done));
	task automatic check(input string what, input logic [127:0] e, g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic report_and_stop();
		if (mismatches == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	// one idle edge first so psel is never assigned twice in a step
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prd;
		check("slave error", 128'h0, 128'(perr));
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic push(input logic [127:0] d);
		sv <= 1'b1;
		sd <= d;
		do begin
			@(posedge clk);
			if (srdy !== 1'b1) full++;
		end while (srdy !== 1'b1);
		exp_q.push_back(d);
	endtask : push
	function automatic logic [15:0] stat_exp(input logic four,
		input logic [2:0] dec);
		logic [7:0] r;
		r = 8'h00;
		if (dec == 3'h0) r = four ? 8'h14 : 8'h0a;
		if (dec == 3'h6) r = four ? 8'h08 : 8'h04;
		if (dec == 3'h7) r = four ? 8'h05 : 8'h00;
		return {r, 1'b0, four ? 3'h2 : 3'h1, 1'b0, four, 1'b0,
			!four && dec == 3'h7};
	endfunction : stat_exp
	// ------------------------------------------------------------
	// receiver compare and hang guard
	// ------------------------------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			mismatches++;
			report_and_stop();
		end else if (done === 1'b1)
			check("lane word", exp_q.size() > 0 ? exp_q.pop_front() : ~word,
				word);
	end
	initial begin
		void'($urandom(70190));
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, dbf_pkg::CTRL_OFS, 32'h0);
		check("ctrl reset", 128'(dbf_pkg::CTRL_RST), 128'(rd));
		check("reset pins", 128'h2, 128'({f2, f1, f0, m40}));
		for (int k = 0; k < 16; k++) begin
			apb(1'b1, dbf_pkg::CTRL_OFS, 32'((k >> 1) << 4 | (k & 1) << 1));
			apb(1'b0, dbf_pkg::STAT_OFS, 32'h0);
			m = (!k[0] && k[3:1] == 3'h7) ? 16'h00ff : 16'hffff;
			check("status", 128'(stat_exp(k[0], k[3:1]) & m),
				128'(rd[15:0] & m));
			check("link pins", k[0] ? 128'h5 : 128'h2,
				128'({f2, f1, f0, m40}));
		end
		apb(1'b1, 12'h00c, 32'hffff_ffff);
		apb(1'b0, 12'h00c, 32'h0);
		check("unmapped", 128'h0, 128'(rd));
		// enabled, but decimation 24/32 on eight lanes must be refused
		apb(1'b1, dbf_pkg::CTRL_OFS, 32'h0000_0071);
		apb(1'b1, dbf_pkg::DROP_OFS, 32'h0);
		n = $urandom_range(20, 1);
		sv <= 1'b1;
		repeat (n) @(posedge clk);
		sv <= 1'b0;
		apb(1'b0, dbf_pkg::DROP_OFS, 32'h0);
		check("drops", 128'(n), 128'(rd));
		// four lanes first: the slow drain fills the fifo until it refuses
		for (int md = 1; md >= 0; md--) begin
			apb(1'b1, dbf_pkg::CTRL_OFS, 32'(1 | md << 1));
			for (int i = 0; i < 12; i++)
				push(i == 0 ? {8{16'hff00}} :
					{$urandom, $urandom, $urandom, $urandom});
			sv <= 1'b0;
			while (exp_q.size() != 0) @(posedge clk);
		end
		check("fifo refused", 128'h1, 128'(full != 0));
		report_and_stop();
	end
endmodule : dbf_framer_test
